//--- src/dccl_pkg.sv
`default_nettype none
package dccl_pkg;
  // Time base
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned INIT_CLR_NS   = 1000;
  localparam int unsigned INIT_CLR_CYC  = (INIT_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MCLK_HALF_NS  = 50;
  localparam int unsigned MCLK_HALF_CYC = (MCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register word indexes
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_BITCNT = 3'h2;
  localparam logic [2:0] REG_PULSES = 3'h3;
  localparam logic [2:0] REG_CFGIDX = 3'h4;
  localparam logic [2:0] REG_CFGDAT = 3'h5;

  // Control fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_PROG_BIT = 2;
  localparam logic [1:0]  MODE_MASTER   = 2'h0;
  localparam logic [1:0]  MODE_SLAVE    = 2'h1;
  localparam logic [1:0]  MODE_SYNCBYTE = 2'h2;
  localparam logic [1:0]  MODE_RST      = MODE_MASTER;

  // Status fields
  localparam int unsigned STAT_DONE_BIT = 0;
  localparam int unsigned STAT_ERR_BIT  = 1;
  localparam int unsigned STAT_LOAD_BIT = 2;
  localparam int unsigned STAT_CONF_BIT = 3;
  localparam int unsigned STAT_INIT_BIT = 4;

  // Stream layout
  localparam int unsigned PRE_BITS = 8;
  localparam int unsigned BYTE_W   = 8;

  typedef enum logic [2:0] {
    ST_WAIT_PROG,
    ST_PROG,
    ST_INIT,
    ST_HEADER,
    ST_FRAMES,
    ST_PASS,
    ST_DONE,
    ST_ERROR
  } dccl_state_t;
endpackage : dccl_pkg
`default_nettype wire

//--- src/dccl_sync.sv
`default_nettype none
module dccl_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk, // System clock
  input  wire logic         srst,    // Sync reset
  input  wire logic [W-1:0] d,       // Asynchronous input
  output logic      [W-1:0] q        // Synchronised output
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : dccl_sync
`default_nettype wire

//--- src/dccl_crc.sv
`default_nettype none
module dccl_crc #(
  parameter int         W    = 16,
  parameter logic [W-1:0] POLY = 16'h1021
) (
  input  wire logic         sys_clk,  // System clock
  input  wire logic         srst,     // Sync reset
  input  wire logic         clr,      // Clear remainder
  input  wire logic         en,       // Shift one bit
  input  wire logic         bit_i,    // Serial bit
  output logic      [W-1:0] crc_next  // Remainder after this bit
);
  logic [W-1:0] crc_q;
  logic         fb;

  assign fb       = crc_q[W-1] ^ bit_i;
  assign crc_next = {crc_q[W-2:0], 1'b0} ^ (fb ? POLY : '0);

  always_ff @(posedge sys_clk) begin
    if (srst || clr) begin
      crc_q <= '0;
    end else if (en) begin
      crc_q <= crc_next;
    end
  end
endmodule : dccl_crc
`default_nettype wire

//--- src/dccl_loader.sv
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`default_nettype none
module dccl_loader
  import dccl_pkg::*;
#(
  parameter int          CNT_W      = 24,
  parameter int          FRAME_W    = 16,
  parameter int          CRC_W      = 16,
  parameter logic [15:0] CRC_POLY   = 16'h1021,
  parameter int          OWN_FRAMES = 64
) (
  input  wire logic              sys_clk,            // 40 MHz clock
  input  wire logic              srst,               // Sync reset, high
  input  wire logic [2:0]        avs_address,        // Word index
  input  wire logic              avs_read,           // Read request
  input  wire logic              avs_write,          // Write request
  input  wire logic [31:0]       avs_writedata,      // Write data
  output logic      [31:0]       avs_readdata,       // Read data
  output logic                   avs_waitrequest,    // Stall
  input  wire logic              config_bit_clock_i, // Link clock in
  output logic                   config_bit_clock_o, // Link clock out
  output logic                   config_bit_clock_oe,// Drive link clock
  input  wire logic              din_i,              // Serial data in
  input  wire logic [BYTE_W-1:0] byte_i,             // Byte data in
  output logic                   byte_ack_o,         // Byte accepted
  output logic                   dout_o,             // Chain data out
  input  wire logic              prog_n_i,           // Program, low pulse
  input  wire logic              init_i,             // Shared init level
  output logic                   init_oe,            // Pull init low
  output logic                   done_oe,            // Pull done low
  output logic                   high_while_loading, // Status, high
  output logic                   low_while_loading,  // Status, low
  output logic                   user_io_en          // User I/O enable
);
  localparam int HDR_BITS = PRE_BITS + CNT_W;
  localparam int HW       = $clog2(HDR_BITS + 1);
  localparam int FR_BITS  = FRAME_W + CRC_W;
  localparam int FW       = $clog2(FR_BITS + 1);
  localparam int MW       = $clog2(OWN_FRAMES);
  localparam int IW       = $clog2(INIT_CLR_CYC + 1);
  localparam int DW       = $clog2(MCLK_HALF_CYC + 1);

  dccl_state_t          state_q, state_d;
  logic [1:0]           mode_q;
  logic                 soft_prog_q;
  logic [MW-1:0]        cfg_idx_q;
  logic                 ack_q;
  logic [31:0]          rdata_q;
  logic [3:0]           sy;
  logic [BYTE_W-1:0]    sy_byte;
  logic                 clk_d1_q;
  logic                 gclk_q;
  logic [DW-1:0]        div_q;
  logic [IW-1:0]        init_cnt_q;
  logic [CNT_W-1:0]     pulse_q;
  logic [CNT_W-1:0]     bitcnt_q;
  logic [HW-1:0]        hdr_cnt_q;
  logic                 fr_busy_q;
  logic [FW-1:0]        fr_cnt_q;
  logic [FRAME_W-1:0]   fr_sh_q;
  logic [MW-1:0]        fr_idx_q;
  logic [FRAME_W-1:0]   cfg_mem [OWN_FRAMES];
  logic                 first_q;
  logic [2:0]           ph_q;
  logic [BYTE_W-1:0]    bsr_q;
  logic                 bacc_q;
  logic [1:0]           p1_q, p2_q;
  logic                 dout_q;

  // Pin synchronisers
  dccl_sync #(.W(4)) u_sync_pins (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d       ({init_i, ~prog_n_i, din_i, config_bit_clock_i}), // Program active high: reset 0 is idle
    .q       (sy)
  );

  dccl_sync #(.W(BYTE_W)) u_sync_byte (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d       (byte_i),
    .q       (sy_byte)
  );

  // Decode
  wire is_master  = (mode_q == MODE_MASTER);
  wire is_byte    = (mode_q == MODE_SYNCBYTE);
  wire loading    = (state_q == ST_HEADER) || (state_q == ST_FRAMES) || (state_q == ST_PASS);
  wire prog_req   = sy[2] | soft_prog_q;
  wire init_timed = (init_cnt_q == IW'(INIT_CLR_CYC));
  wire tick       = (div_q == DW'(MCLK_HALF_CYC - 1));
  wire run        = is_master & loading;
  wire grise      = run & tick & ~gclk_q;
  wire gfall      = run & tick & gclk_q;
  wire srise      = sy[0] & ~clk_d1_q;
  wire sfall      = ~sy[0] & clk_d1_q;
  wire rise       = loading & (is_master ? grise : srise);
  wire fall       = is_master ? gfall : sfall;
  wire bit_v      = rise & ~(is_byte & first_q);
  wire bit_w      = ~is_byte ? sy[1] :
                    (ph_q == 3'h0) ? sy_byte[BYTE_W-1] : bsr_q[3'h7 - ph_q];
  wire [CNT_W-1:0] pulse_n = pulse_q + CNT_W'(1);
  wire cnt_hit    = (pulse_n == bitcnt_q);
  wire hdr_last   = (hdr_cnt_q == HW'(HDR_BITS - 1));
  wire in_frames  = bit_v & (state_q == ST_FRAMES);
  wire crc_clr    = in_frames & ~fr_busy_q & ~bit_w;
  wire crc_en     = in_frames & fr_busy_q;
  wire fr_end     = crc_en & (fr_cnt_q == FW'(FR_BITS - 1));
  wire [CRC_W-1:0] crc_next;
  wire fr_bad     = fr_end & (crc_next != '0);
  wire fr_good    = fr_end & (crc_next == '0);
  wire own_last   = (fr_idx_q == MW'(OWN_FRAMES - 1));
  wire fwd_tag    = (state_q == ST_HEADER) || (state_q == ST_PASS);
  wire two_stage  = is_master | is_byte;
  wire acc        = (avs_read | avs_write) & ~ack_q;
  wire wr_en      = avs_write & ack_q;

  dccl_crc #(.W(CRC_W), .POLY(CRC_POLY)) u_crc (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .clr      (crc_clr),
    .en       (crc_en),
    .bit_i    (bit_w),
    .crc_next (crc_next)
  );

  // Load sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_WAIT_PROG: if (is_master) state_d = ST_INIT;
      ST_PROG:      state_d = ST_INIT;
      ST_INIT:      if (init_timed && sy[3]) state_d = ST_HEADER;
      ST_HEADER:    if (bit_v && hdr_last) state_d = ST_FRAMES;
      ST_FRAMES: begin
        if (fr_bad) begin
          state_d = ST_ERROR;
        end else if (bit_v && cnt_hit) begin
          state_d = ST_DONE;
        end else if (fr_good && own_last) begin
          state_d = ST_PASS;
        end
      end
      ST_PASS:      if (bit_v && cnt_hit) state_d = ST_DONE;
      default:      state_d = state_q;
    endcase
    if (prog_req) begin
      state_d = ST_PROG;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= ST_WAIT_PROG;
    end else begin
      state_q <= state_d;
    end
  end

  // Link clock edges; head device makes its own clock
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clk_d1_q <= 1'b0;
      gclk_q   <= 1'b0;
      div_q    <= '0;
    end else begin
      clk_d1_q <= sy[0];
      if (!run) begin
        gclk_q <= 1'b0;
        div_q  <= '0;
      end else if (tick) begin
        gclk_q <= ~gclk_q;
        div_q  <= '0;
      end else begin
        div_q  <= div_q + DW'(1);
      end
    end
  end

  // Init clearing time
  always_ff @(posedge sys_clk) begin
    if (srst || state_q != ST_INIT) begin
      init_cnt_q <= '0;
    end else if (!init_timed) begin
      init_cnt_q <= init_cnt_q + IW'(1);
    end
  end

  // Pulse and header counters
  always_ff @(posedge sys_clk) begin
    if (srst || state_q == ST_PROG) begin
      pulse_q   <= '0;
      bitcnt_q  <= '0;
      hdr_cnt_q <= '0;
    end else if (bit_v) begin
      pulse_q <= pulse_n;
      if (state_q == ST_HEADER) begin
        hdr_cnt_q <= hdr_cnt_q + HW'(1);
        if (hdr_cnt_q >= HW'(PRE_BITS)) begin
          bitcnt_q <= {bitcnt_q[CNT_W-2:0], bit_w};
        end
      end
    end
  end

  // Frame receiver
  always_ff @(posedge sys_clk) begin
    if (srst || state_q == ST_PROG) begin
      fr_busy_q <= 1'b0;
      fr_cnt_q  <= '0;
      fr_sh_q   <= '0;
      fr_idx_q  <= '0;
    end else if (crc_clr) begin
      fr_busy_q <= 1'b1;
      fr_cnt_q  <= '0;
    end else if (crc_en) begin
      fr_cnt_q <= fr_cnt_q + FW'(1);
      if (fr_cnt_q < FW'(FRAME_W)) begin
        fr_sh_q <= {fr_sh_q[FRAME_W-2:0], bit_w};
      end
      if (fr_end) begin
        fr_busy_q <= 1'b0;
      end
      if (fr_good && !own_last) begin
        fr_idx_q <= fr_idx_q + MW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (fr_good) begin
      cfg_mem[fr_idx_q] <= fr_sh_q;
    end
  end

  // Byte serialiser
  always_ff @(posedge sys_clk) begin
    if (srst || !is_byte || !loading) begin
      first_q <= 1'b1;
      ph_q    <= '0;
      bsr_q   <= '0;
      bacc_q  <= 1'b0;
    end else if (rise) begin
      bacc_q <= 1'b0;
      if (first_q) begin
        first_q <= 1'b0;
      end else begin
        ph_q <= ph_q + 3'h1;
        if (ph_q == 3'h0) begin
          bsr_q  <= sy_byte;
          bacc_q <= 1'b1;
        end
      end
    end
  end

  // Chain output: rise-captured, driven on falling edges
  always_ff @(posedge sys_clk) begin
    if (srst || state_q == ST_PROG) begin
      p1_q   <= '0;
      p2_q   <= '0;
      dout_q <= 1'b1;
    end else begin
      if (bit_v) begin
        p1_q <= {fwd_tag, bit_w};
        p2_q <= p1_q;
      end
      if (fall) begin
        if (two_stage) begin
          dout_q <= p2_q[1] ? p2_q[0] : 1'b1;
        end else begin
          dout_q <= p1_q[1] ? p1_q[0] : 1'b1;
        end
      end
    end
  end

  // Register bus
  wire [31:0] stat_w = 32'(
    (32'(state_q == ST_DONE)  << STAT_DONE_BIT) |
    (32'(state_q == ST_ERROR) << STAT_ERR_BIT)  |
    (32'(loading)             << STAT_LOAD_BIT) |
    (32'((state_q == ST_PASS) || (state_q == ST_DONE)) << STAT_CONF_BIT) |
    (32'(sy[3])               << STAT_INIT_BIT));
  wire [31:0] rd_mux =
    (avs_address == REG_CTRL)   ? 32'(mode_q) :
    (avs_address == REG_STATUS) ? stat_w :
    (avs_address == REG_BITCNT) ? 32'(bitcnt_q) :
    (avs_address == REG_PULSES) ? 32'(pulse_q) :
    (avs_address == REG_CFGIDX) ? 32'(cfg_idx_q) :
    (avs_address == REG_CFGDAT) ? 32'(cfg_mem[cfg_idx_q]) : 32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack_q       <= 1'b0;
      rdata_q     <= '0;
      mode_q      <= MODE_RST;
      soft_prog_q <= 1'b0;
      cfg_idx_q   <= '0;
    end else begin
      ack_q       <= acc;
      soft_prog_q <= 1'b0;
      if (acc && avs_read) begin
        rdata_q <= rd_mux;
      end
      if (wr_en && avs_address == REG_CTRL) begin
        mode_q      <= avs_writedata[CTRL_MODE_LSB +: 2];
        soft_prog_q <= avs_writedata[CTRL_PROG_BIT];
      end else if (wr_en && avs_address == REG_CFGIDX) begin
        cfg_idx_q <= avs_writedata[MW-1:0];
      end
    end
  end

  // Outputs
  assign avs_waitrequest     = acc;
  assign avs_readdata        = rdata_q;
  assign config_bit_clock_o  = gclk_q;
  assign config_bit_clock_oe = is_master;
  assign dout_o              = dout_q;
  assign byte_ack_o          = bacc_q;
  assign init_oe             = (state_q == ST_PROG) || (state_q == ST_ERROR) ||
                               ((state_q == ST_INIT) && !init_timed);
  assign done_oe             = (state_q != ST_DONE);
  assign user_io_en          = (state_q == ST_DONE);
  assign high_while_loading  = loading;
  assign low_while_loading   = ~loading;
endmodule : dccl_loader
`default_nettype wire

//--- tb/dccl_loader_props.sv
`default_nettype none
module dccl_loader_props (
  input wire logic sys_clk,             // Clock
  input wire logic srst,                // Reset
  input wire logic config_bit_clock_i,  // Link clock
  input wire logic config_bit_clock_oe, // Link drive
  input wire logic byte_ack_o,          // Byte accept
  input wire logic dout_o,              // Chain out
  input wire logic init_i,              // Init level
  input wire logic init_oe,             // Init pull
  input wire logic done_oe,             // Done pull
  input wire logic high_while_loading,  // Status high
  input wire logic low_while_loading,   // Status low
  input wire logic user_io_en           // User I/O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_status_pair: assert property (low_while_loading == !high_while_loading)
    else $error("status pins not complementary");
  a_load_released: assert property (high_while_loading |-> !init_oe && done_oe)
    else $error("loading while init or done released wrongly");
  a_init_first: assert property (
    $rose(high_while_loading) |-> $past(init_i) && $past(init_i, 2))
    else $error("loading began before init was high");
  a_done_io: assert property (!done_oe |-> user_io_en && !high_while_loading)
    else $error("done without user io enable");
  a_io_done: assert property (user_io_en |-> !done_oe && !init_oe)
    else $error("user io enabled before done");
  a_err_hold: assert property (
    $fell(high_while_loading) && init_oe |-> init_oe [*8])
    else $error("init pull released on its own");
  a_ack_len: assert property (
    $rose(byte_ack_o) |-> byte_ack_o [*6] ##[1:3] !byte_ack_o)
    else $error("byte accept not one link period");
  a_ack_cause: assert property (
    $rose(byte_ack_o) |-> high_while_loading && $past(config_bit_clock_i))
    else $error("byte accept without link rise");
  a_dout_fall: assert property (
    $changed(dout_o) && high_while_loading && !config_bit_clock_oe
    |-> !$past(config_bit_clock_i))
    else $error("chain out changed off a falling edge");
  a_dout_idle: assert property (init_oe && $past(init_oe, 8) |-> dout_o)
    else $error("chain out not idle high");
endmodule : dccl_loader_props

bind dccl_loader dccl_loader_props u_props (
  .sys_clk, .srst, .config_bit_clock_i, .config_bit_clock_oe, .byte_ack_o, .dout_o,
  .init_i, .init_oe, .done_oe, .high_while_loading, .low_while_loading, .user_io_en
);
`default_nettype wire

//--- tb/dccl_host_model.sv
`default_nettype none
module dccl_host_model (
  output logic       host_clk, // Link clock
  output logic       din_i,    // Serial data
  output logic [7:0] byte_i    // Byte data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    host_clk = 1'b0;
    din_i    = 1'b1;
    byte_i   = 8'h00;
  end
  // Clock runs only within a transfer and rests low between them
  task automatic pulse(input logic b);
    #3 din_i = b;
    #97 host_clk = 1'b1;
    #100 host_clk = 1'b0;
  endtask : pulse
  // Byte held across the eight pulses that shift it
  task automatic send_byte(input logic [7:0] b);
    byte_i = b;
    repeat (8) pulse(!din_i);
  endtask : send_byte
  // Released lines show the inverse of the last value
  task automatic idle;
    din_i  = !din_i;
    byte_i = ~byte_i;
  endtask : idle
endmodule : dccl_host_model
`default_nettype wire

//--- tb/test_daisy_chain_config_loader.sv
`default_nettype none
module test_daisy_chain_config_loader import dccl_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic [2:0]  avs_address = 3'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        prog_n_i = 1'b1;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, config_bit_clock_i, config_bit_clock_o, config_bit_clock_oe;
  logic        din_i, byte_ack_o, dout_o, init_i, init_oe, done_oe, host_clk;
  logic        high_while_loading, low_while_loading, user_io_en;
  logic [7:0]  byte_i;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          n_ack = 0;
  int          m;
  logic [15:0] fd[$];
  logic        ack_q = 1'b0;
  logic [15:0] seed = 16'h25C5;
  logic [31:0] hw = 32'hA50003E8;
  logic [31:0] rq[$];
  logic        dq[$];
  logic        bq[$];

  always #12.5 sys_clk = ~sys_clk;
  // Open-drain init wire with pull-up; link clock pin shared with the host
  assign init_i = !init_oe;
  assign config_bit_clock_i = config_bit_clock_oe ? config_bit_clock_o : host_clk;

  dccl_loader #(.OWN_FRAMES(2)) dut (
    .sys_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .config_bit_clock_i, .config_bit_clock_o, .config_bit_clock_oe,
    .din_i, .byte_i, .byte_ack_o, .dout_o, .prog_n_i, .init_i, .init_oe, .done_oe,
    .high_while_loading, .low_while_loading, .user_io_en
  );
  dccl_host_model u_host (.host_clk, .din_i, .byte_i);

  task automatic print_verdict;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  task automatic fail;
    n_mismatch++;
    print_verdict();
  endtask : fail

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [15:0] crc16(input logic [15:0] d);
    logic [15:0] c;
    c = 16'h0;
    for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0);
    return c;
  endfunction : crc16

  // Entered right after a clock edge; leaves one idle cycle behind
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n == 50) fail();
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic add(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) bq.push_back(v[i]);
  endtask : add

  task automatic header(input logic [23:0] cnt);
    bq.delete();
    add(32'hA5, 8);
    add({8'h00, cnt}, 24);
  endtask : header

  task automatic frame(input logic bad);
    logic [15:0] d;
    seed = lfsr(seed);
    d = seed;
    fd.push_back(d);
    add(32'h0, 1);
    add({16'h0, d}, 16);
    add({16'h0, crc16(d) ^ {15'h0, bad}}, 16);
  endtask : frame

  task automatic start(input logic [1:0] m, input logic by_reg);
    int n;
    bus(1'b1, REG_CTRL, {29'h0, by_reg, m});
    prog_n_i <= by_reg;
    repeat (4) @(posedge sys_clk);
    prog_n_i <= 1'b1;
    for (n = 0; n < 200 && init_oe !== 1'b1; n++) @(posedge sys_clk);
    while (n < 200 && init_oe !== 1'b0) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 200) fail();
    repeat (8) @(posedge sys_clk);
  endtask : start

  // Header forwarded half a link cycle late, idle high over own frames, then passed on
  task automatic run(input logic chk);
    for (int k = 0; k < bq.size(); k++) begin
      if (chk && k > 0) dq.push_back((k < 33 || k > 98) ? bq[k-1] : 1'b1);
      u_host.pulse(bq[k]);
    end
    u_host.idle();
    repeat (20) @(posedge sys_clk);
  endtask : run

  always @(posedge sys_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rq.size() > 0) begin
      check("readdata", avs_readdata, rq.pop_front());
    end
    ack_q <= byte_ack_o;
    if (byte_ack_o === 1'b1 && ack_q === 1'b0) n_ack++;
  end

  always @(posedge config_bit_clock_i) begin
    if (dq.size() > 0) begin
      check("dout", {31'h0, dout_o}, {31'h0, dq.pop_front()});
    end
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rd(3'h6, 32'h0);
    rd(REG_CTRL, 32'h0);
    check("clk_oe", {31'h0, config_bit_clock_oe}, 32'h1);
    // Head device starts on its own after reset and drives its link clock
    m = 0;
    while (m < 200 && config_bit_clock_o !== 1'b1) begin
      @(posedge sys_clk);
      m++;
    end
    if (m == 200) fail();
    m = 0;
    while (m < 100 && config_bit_clock_o !== 1'b0) begin
      @(posedge sys_clk);
      m++;
    end
    while (m < 100 && config_bit_clock_o !== 1'b1) begin
      @(posedge sys_clk);
      m++;
    end
    check("mclk_period", 32'(m), 32'(2 * MCLK_HALF_CYC));
    start(MODE_SLAVE, 1'b0);
    header(24'h83);
    frame(1'b0);
    frame(1'b1);
    run(1'b0);
    rd(REG_STATUS, 32'h02);
    check("init_oe", {31'h0, init_oe}, 32'h1);
    start(MODE_SLAVE, 1'b0);
    header(24'h83);
    repeat (3) frame(1'b0);
    run(1'b1);
    for (int i = 0; i < 4 && done_oe !== 1'b0; i++) u_host.pulse(1'b1);
    repeat (20) @(posedge sys_clk);
    rd(REG_STATUS, 32'h19);
    rd(REG_BITCNT, 32'h83);
    rd(REG_PULSES, 32'h83);
    check("user_io_en", {31'h0, user_io_en}, 32'h1);
    bus(1'b1, REG_CFGIDX, 32'h1);
    rd(REG_CFGDAT, {16'h0, fd[3]});
    start(MODE_SYNCBYTE, 1'b1);
    rd(REG_CTRL, 32'h2);
    u_host.pulse(1'b1);
    for (int i = 3; i >= 0; i--) u_host.send_byte(hw[i*8 +: 8]);
    u_host.idle();
    repeat (20) @(posedge sys_clk);
    rd(REG_PULSES, 32'h20);
    rd(REG_BITCNT, 32'h3E8);
    rd(REG_STATUS, 32'h14);
    check("byte_ack", 32'(n_ack), 32'h4);
    print_verdict();
  end
endmodule : test_daisy_chain_config_loader
`default_nettype wire
